// >>> design/led_dimming_phase_startup_ctrl.sv
// led_dimming_phase_startup_ctrl.sv: dimming enables, soft-start sequencing, fault flag, dither
// assumes all inputs synchronous to REF_CLK, analog results arrive as digital levels
//
// Contract
// [RL1] sample dimming at 10MHz, derive enables
// [RL2] phase step is period divided by n
// [RL3] channel one first, channel six last
// [RL4] latch phase select once at power-up
// [RL5] phase off: all enables follow dimming
// [RL6] faulted string keeps original slots
// [RL7] host changes dimming only while disabled
// [RL8] unused channels from highest number down
// [RL9] paralleled sinks need phase select low
// [RL10] stay off until both supplies valid
// [RL11] enable rise starts; enable low shuts
// [RL12] power-up checks disable unused channels permanently
// [RL13] classify short, unused per comparator
// [RL14] stage one steps DAC, fixed 50ms
// [RL15] stage two after stage one and dimming high
// [RL16] DAC update each dim rise or 10ms
// [RL17] fault flag low on open, short, thermal
// [RL18] short and thermal faults release immediately
// [RL19] open fault latched until enable toggle
// [RL20] spread spectrum keeps 94% to 106%
// [RL21] host keeps dimming 100Hz to 3kHz
// [RL22] period from first two pulses, fixed
// [RL23] pulse width applied next period
// [RL24] string count fixed from checks
`timescale 1ns/10ps
`include "dim_ctrl_defs.svh"
module led_dimming_phase_startup_ctrl
  import dim_ctrl_pkg::*;
#(
  parameter int STAGE1_CYCLES  = `STAGE1_CYC,
  parameter int DAC_HOLD_CYCLES = `DAC_HOLD_CYC
) (
  input  wire logic             REF_CLK,
  input  wire logic             RST,
  input  wire logic             DIM_IN,
  input  wire logic             ENABLE,
  input  wire logic             PHASE_SHIFT_SELECT,
  input  wire logic             IN_UNDERVOLTAGE_LOCKOUT_OK,
  input  wire logic             VCC_UNDERVOLTAGE_LOCKOUT_OK,
  input  wire logic [5:0]       CH_BELOW_SHORT,
  input  wire logic [5:0]       CH_BELOW_UNUSED,
  input  wire logic             HALF_OVP_REACHED,
  input  wire logic             MIN_OUT_LOW,
  input  wire logic             MIN_OUT_HIGH,
  input  wire logic [5:0]       CH_OPEN,
  input  wire logic [5:0]       CH_SHORT,
  input  wire logic             THERMAL_SHUTDOWN,
  input  wire logic             SPREAD_SPECTRUM_MODE,
  output logic      [5:0]       STRING_EN,
  output logic      [7:0]       DAC_CODE,
  output logic                  CONVERTER_RUN,
  output logic      [5:0]       CH_UNUSED,
  output logic      [5:0]       CH_GND_SHORT,
  output logic      [7:0]       DITHER_PERMIL,
  output logic                  DITHER_UP,
  output logic                  FAULT_FLAG_N_O,
  output logic                  FAULT_FLAG_N_OE
);

  // ----------------------------------------------------------------
  // sampling and edges
  // ----------------------------------------------------------------
  logic             tick_reg;
  logic             dim_s_reg;
  logic             dim_p_reg;
  logic             en_p_reg;
  logic             ps_latched_reg;
  logic             ps_taken_reg;
  logic             dim_rise;
  logic             en_rise;
  logic             pwr_ok;

  assign pwr_ok   = IN_UNDERVOLTAGE_LOCKOUT_OK & VCC_UNDERVOLTAGE_LOCKOUT_OK;
  assign dim_rise = tick_reg & dim_s_reg & ~dim_p_reg;
  assign en_rise  = ENABLE & ~en_p_reg;

  // a 20 MHz clock halved gives the 10 MHz dimming sample tick
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      tick_reg  <= 1'b0;
      dim_s_reg <= 1'b0;
      dim_p_reg <= 1'b0;
    end else begin
      tick_reg <= ~tick_reg;
      if (tick_reg) begin
        dim_s_reg <= DIM_IN; // RL1
        dim_p_reg <= dim_s_reg;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      en_p_reg <= 1'b0;
    end else begin
      en_p_reg <= ENABLE;
    end
  end

  // phase select caught once after the first clean power-up, never again
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ps_latched_reg <= 1'b0;
      ps_taken_reg   <= 1'b0;
    end else if (!ps_taken_reg && pwr_ok) begin
      ps_latched_reg <= PHASE_SHIFT_SELECT; // RL4
      ps_taken_reg   <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // startup sequencer
  // ----------------------------------------------------------------
  seq_state_t       seq_reg;
  logic [23:0]      tmr_reg;
  logic [7:0]       dac_reg;
  logic [5:0]       unused_reg;
  logic [5:0]       gshort_reg;
  logic [2:0]       nstr_reg;
  logic             running;
  logic             conv_run_reg;

  assign running = (seq_reg == ST_RUN);

  // converter-run pin taken from a flop; lags the state by one cycle
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      conv_run_reg <= 1'b0;
    end else begin
      conv_run_reg <= (seq_reg == ST_RAMP1) | (seq_reg == ST_WAIT2) | running;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      seq_reg    <= ST_OFF;
      tmr_reg    <= 24'h000000;
      dac_reg    <= `DAC_RESET;
      unused_reg <= 6'h00;
      gshort_reg <= 6'h00;
      nstr_reg   <= 3'h0;
    end else if (!ENABLE || !pwr_ok) begin
      seq_reg <= ST_OFF; // RL10 RL11
      tmr_reg <= 24'h000000;
      dac_reg <= `DAC_RESET;
    end else begin
      case (seq_reg)
        ST_OFF: begin
          if (en_rise || en_p_reg) begin
            seq_reg <= ST_CHECK; // RL11
            tmr_reg <= 24'h000000;
          end
        end
        ST_CHECK: begin
          tmr_reg <= tmr_reg + 24'h000001;
          if (tmr_reg == 24'(`CHECK_CYC - 1)) begin
            gshort_reg <= CH_BELOW_SHORT; // RL13
            unused_reg <= CH_BELOW_UNUSED & ~CH_BELOW_SHORT; // RL12 RL13
            nstr_reg   <= 3'(`NUM_CH) - 3'($countones(CH_BELOW_UNUSED & ~CH_BELOW_SHORT)); // RL24
            seq_reg    <= ST_RAMP1;
            tmr_reg    <= 24'h000000;
          end
        end
        ST_RAMP1: begin
          tmr_reg <= tmr_reg + 24'h000001;
          if (!HALF_OVP_REACHED && dac_reg != 8'hff) begin
            dac_reg <= dac_reg + 8'h01; // RL14
          end
          if (tmr_reg == 24'(STAGE1_CYCLES - 1)) begin
            seq_reg <= ST_WAIT2; // RL14
          end
        end
        ST_WAIT2: begin
          tmr_reg <= 24'h000000;
          if (dim_s_reg) begin
            seq_reg <= ST_RUN; // RL15
          end
        end
        ST_RUN: begin
          // update on each dimming rise, or every hold time while dimming stays high
          if (dim_rise || tmr_reg == 24'(DAC_HOLD_CYCLES - 1)) begin // RL16
            tmr_reg <= 24'h000000;
            if (MIN_OUT_LOW && dac_reg != 8'hff) begin
              dac_reg <= dac_reg + 8'h01; // RL15
            end else if (MIN_OUT_HIGH && dac_reg != 8'h00) begin
              dac_reg <= dac_reg - 8'h01; // RL15
            end
          end else if (dim_s_reg) begin
            tmr_reg <= tmr_reg + 24'h000001;
          end else begin
            tmr_reg <= 24'h000000;
          end
        end
        default: seq_reg <= ST_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // period and width capture
  // ----------------------------------------------------------------
  meas_state_t      meas_reg;
  logic [23:0]      per_cnt_reg;
  logic [23:0]      period_reg;
  logic [23:0]      wid_cnt_reg;
  logic [23:0]      width_reg;
  logic [23:0]      width_next_reg;

  // period locked from the first two pulses; widths staged one period late
  always_ff @(posedge REF_CLK) begin
    if (RST || !ENABLE) begin
      meas_reg       <= MEAS_IDLE;
      per_cnt_reg    <= 24'h000000;
      period_reg     <= 24'h000000;
      wid_cnt_reg    <= 24'h000000;
      width_reg      <= 24'h000000;
      width_next_reg <= 24'h000000;
    end else if (tick_reg) begin
      per_cnt_reg <= per_cnt_reg + 24'h000001;
      if (dim_s_reg) begin
        wid_cnt_reg <= wid_cnt_reg + 24'h000001;
      end
      case (meas_reg)
        MEAS_IDLE: begin
          if (dim_s_reg && !dim_p_reg) begin
            meas_reg    <= MEAS_FIRST;
            per_cnt_reg <= 24'h000001;
            wid_cnt_reg <= 24'h000001;
          end
        end
        MEAS_FIRST: begin
          if (dim_s_reg && !dim_p_reg) begin
            period_reg     <= per_cnt_reg; // RL22
            width_next_reg <= wid_cnt_reg;
            meas_reg       <= MEAS_LOCK;
            per_cnt_reg    <= 24'h000001;
            wid_cnt_reg    <= 24'h000001;
          end
        end
        MEAS_LOCK: begin
          if (per_cnt_reg == period_reg) begin
            per_cnt_reg    <= 24'h000001;
            width_reg      <= width_next_reg; // RL23
            width_next_reg <= wid_cnt_reg;
            wid_cnt_reg    <= 24'(dim_s_reg);
          end
        end
        default: meas_reg <= MEAS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // per-string enables
  // ----------------------------------------------------------------
  logic [23:0]      step;
  logic [5:0]       str_en_next;
  logic [5:0]       str_en_reg;

  assign step = (nstr_reg == 3'h0) ? 24'h000000 : period_reg / 24'(nstr_reg); // RL2

  for (genvar i = 0; i < `NUM_CH; i++) begin : g_ch
    logic [23:0] ofs;
    logic [23:0] pos;
    assign ofs = step * 24'(i); // RL3 RL6
    assign pos = (per_cnt_reg >= ofs) ? per_cnt_reg - ofs : per_cnt_reg + period_reg - ofs;
    always_comb begin
      if (!running || unused_reg[i] || CH_OPEN[i] || CH_SHORT[i]) begin
        str_en_next[i] = 1'b0; // RL12
      end else if (!ps_latched_reg || meas_reg != MEAS_LOCK) begin
        str_en_next[i] = dim_s_reg; // RL5
      end else begin
        str_en_next[i] = (pos < width_reg); // RL2 RL23
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      str_en_reg <= 6'h00;
    end else begin
      str_en_reg <= str_en_next;
    end
  end

  // ----------------------------------------------------------------
  // fault flag
  // ----------------------------------------------------------------
  logic             open_lat_reg;
  logic             flt_oe_reg;

  // open latch cleared only by an enable toggle or reset
  always_ff @(posedge REF_CLK) begin
    if (RST || en_rise) begin
      open_lat_reg <= 1'b0; // RL19
    end else if (running && |(CH_OPEN & ~unused_reg)) begin
      open_lat_reg <= 1'b1; // RL19
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      flt_oe_reg <= 1'b0;
    end else begin
      flt_oe_reg <= open_lat_reg | THERMAL_SHUTDOWN | |(CH_SHORT & ~unused_reg); // RL17 RL18
    end
  end

  // ----------------------------------------------------------------
  // spread-spectrum dither
  // ----------------------------------------------------------------
  logic [7:0]       lfsr_reg;
  logic [7:0]       dith_reg;
  logic             dup_reg;

  // lfsr draws a deviation up to 6.0 percent in per-mille, sign from a bit
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      lfsr_reg <= `SSM_SEED;
      dith_reg <= 8'h00;
      dup_reg  <= 1'b0;
    end else begin
      lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
      if (!SPREAD_SPECTRUM_MODE) begin
        dith_reg <= 8'h00;
      end else if (tick_reg) begin
        dith_reg <= ({2'b00, lfsr_reg[5:0]} > `SSM_MAX * 8'h05) ? `SSM_MAX * 8'h05
                                                               : {2'b00, lfsr_reg[5:0]}; // RL20
        dup_reg  <= lfsr_reg[7];
      end
    end
  end

  assign STRING_EN       = str_en_reg;
  assign DAC_CODE        = dac_reg;
  assign CONVERTER_RUN   = conv_run_reg;
  assign CH_UNUSED       = unused_reg;
  assign CH_GND_SHORT    = gshort_reg;
  assign DITHER_PERMIL   = dith_reg;
  assign DITHER_UP       = dup_reg;
  assign FAULT_FLAG_N_O  = 1'b0;
  assign FAULT_FLAG_N_OE = flt_oe_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_en_drop;
    !ENABLE;
  endsequence

  off_when_disabled_a: assert property (@(posedge REF_CLK) disable iff (RST) // RL11
    s_en_drop |=> !running)
    else $error("sequencer running while enable low");
  undervoltage_lockout_keeps_off_a: assert property (@(posedge REF_CLK) disable iff (RST) // RL10
    !IN_UNDERVOLTAGE_LOCKOUT_OK |=> seq_reg == ST_OFF)
    else $error("sequencer left off state under lockout");
  unused_never_on_a: assert property (@(posedge REF_CLK) disable iff (RST) // RL12
    (STRING_EN & CH_UNUSED) == 6'h00)
    else $error("unused channel enabled");
  thermal_flag_a: assert property (@(posedge REF_CLK) disable iff (RST) // RL17
    THERMAL_SHUTDOWN |=> FAULT_FLAG_N_OE)
    else $error("fault flag not driven during thermal");
  short_release_a: assert property (@(posedge REF_CLK) disable iff (RST) // RL18
    (!THERMAL_SHUTDOWN && CH_SHORT == 6'h00 && !open_lat_reg) |=> !FAULT_FLAG_N_OE)
    else $error("fault flag held without cause");
  open_latch_a: assert property (@(posedge REF_CLK) disable iff (RST) // RL19
    open_lat_reg && !en_rise |=> open_lat_reg)
    else $error("open fault latch dropped");
  sync_dim_a: assert property (@(posedge REF_CLK) disable iff (RST) // RL5
    running && !ps_latched_reg && (CH_OPEN | CH_SHORT) == 6'h00
      |=> STRING_EN == ({6{$past(dim_s_reg)}} & ~$past(unused_reg)))
    else $error("simultaneous enables not following dimming");
  stage2_gate_a: assert property (@(posedge REF_CLK) disable iff (RST) // RL15
    seq_reg == ST_WAIT2 && ENABLE && pwr_ok && !dim_s_reg |=> seq_reg != ST_RUN)
    else $error("stage two entered with dimming low");
  dither_bound_a: assert property (@(posedge REF_CLK) disable iff (RST) // RL20
    DITHER_PERMIL <= 8'h3c)
    else $error("dither beyond six percent");

endmodule

// >>> common/dim_ctrl_defs.svh
// dim_ctrl_defs.svh: widths, counts and timing constants for the dimming/startup block
// assumes a 20 MHz REF_CLK; sampling tick is derived from it
`ifndef DIM_CTRL_DEFS_SVH
`define DIM_CTRL_DEFS_SVH
`define CLK_HZ           20000000
`define SAMPLE_HZ        10000000
`define SAMPLE_DIV       (`CLK_HZ / `SAMPLE_HZ)
`define STAGE1_MS        50
`define STAGE1_CYC       (`STAGE1_MS * (`CLK_HZ / 1000))
`define DAC_HOLD_MS      10
`define DAC_HOLD_CYC     (`DAC_HOLD_MS * (`CLK_HZ / 1000))
`define CHECK_CYC        16
`define NUM_CH           6
`define DAC_W            8
`define DAC_RESET        8'h00
`define PER_W            24
`define SSM_MAX          8'h0c
`define SSM_SEED         8'h5a
`endif

// >>> common/dim_ctrl_pkg.sv
// dim_ctrl_pkg.sv: types of the dimming/startup block
// assumes nothing beyond the defs header
package dim_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_CHECK = 3'b001,
    ST_RAMP1 = 3'b010,
    ST_WAIT2 = 3'b011,
    ST_RUN   = 3'b100
  } seq_state_t;
  typedef enum logic [1:0] {
    MEAS_IDLE  = 2'b00,
    MEAS_FIRST = 2'b01,
    MEAS_LOCK  = 2'b10
  } meas_state_t;
endpackage

// >>> testbench/dim_source.sv
// dim_source.sv: behavioural host that drives the dimming input
// assumes it shares REF_CLK with the block and runs from time zero
`timescale 1ns/10ps
module dim_source #(
  parameter int PER = 600,
  parameter int HI  = 200
) (
  input  wire logic clk,
  output logic      dim
);
  int   cnt = 0;
  logic d   = 1'b0;
  // one fixed period for the whole run, never changed while enabled
  // rate sits above the advised band, still permitted, keeps runs short
  always_ff @(posedge clk) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    d   <= (cnt < HI);
  end
  assign dim = d;
endmodule

// >>> testbench/tb.sv
// tb.sv: self-checking bench for the dimming and startup block
// assumes dim_source drives the dimming input; stage counts shortened
`timescale 1ns/10ps
module tb;
  import dim_ctrl_pkg::*;
  localparam int PER = 600;
  logic       ref_clk = 1'b0;
  logic       rst     = 1'b1;
  logic       en      = 1'b0;
  logic       pss     = 1'b1;
  logic       in_ok   = 1'b0;
  logic       vcc_ok  = 1'b1;
  logic [5:0] bshort  = 6'h00;
  logic [5:0] bunused = 6'h30; // unused strings from the top down
  logic       half    = 1'b0;
  logic       mlow    = 1'b0;
  logic       mhigh   = 1'b0;
  logic [5:0] copen   = 6'h00;
  logic [5:0] cshort  = 6'h00;
  logic       therm   = 1'b0;
  logic       spread_spectrum_mode     = 1'b0;
  logic       dim;
  logic [5:0] str_en;
  logic [5:0] unused;
  logic [5:0] gshort;
  logic [7:0] dac;
  logic [7:0] dith;
  logic       run;
  logic       flt_o;
  logic       flt_oe;
  logic       dup;
  logic       w;
  logic [7:0] d0;
  int         err_total = 0;
  int         cmp_count = 0;
  int         cyc       = 0;
  int         sel       = 0;
  int         t0;

  initial forever #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  // one watched level so every wait shares a single bounded loop
  always_comb w = (sel < 6) ? str_en[sel] : (sel == 6) ? dim : run;

  dim_source #(.PER(PER), .HI(200)) i_dim_source (.clk(ref_clk), .dim(dim));
  led_dimming_phase_startup_ctrl #(
    .STAGE1_CYCLES(40),
    .DAC_HOLD_CYCLES(1000)
  ) i_led_dimming_phase_startup_ctrl (
    .REF_CLK(ref_clk),
    .RST(rst),
    .DIM_IN(dim),
    .ENABLE(en),
    .PHASE_SHIFT_SELECT(pss),
    .IN_UNDERVOLTAGE_LOCKOUT_OK(in_ok),
    .VCC_UNDERVOLTAGE_LOCKOUT_OK(vcc_ok),
    .CH_BELOW_SHORT(bshort),
    .CH_BELOW_UNUSED(bunused),
    .HALF_OVP_REACHED(half),
    .MIN_OUT_LOW(mlow),
    .MIN_OUT_HIGH(mhigh),
    .CH_OPEN(copen),
    .CH_SHORT(cshort),
    .THERMAL_SHUTDOWN(therm),
    .SPREAD_SPECTRUM_MODE(spread_spectrum_mode),
    .STRING_EN(str_en),
    .DAC_CODE(dac),
    .CONVERTER_RUN(run),
    .CH_UNUSED(unused),
    .CH_GND_SHORT(gshort),
    .DITHER_PERMIL(dith),
    .DITHER_UP(dup),
    .FAULT_FLAG_N_O(flt_o),
    .FAULT_FLAG_N_OE(flt_oe)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // cycle distances allow for the 10 MHz sampling grain
  task automatic chk_near(input int got, input int exp);
    cmp_count++;
    if (got < exp - 3 || got > exp + 3) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_w(input int s, input logic lvl);
    int i;
    sel = s;
    #1;
    for (i = 0; i < 5000 && w !== lvl; i++) @(negedge ref_clk);
    if (w !== lvl) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, w, lvl);
      tally_and_finish();
    end
  endtask
  task automatic rise(input int s);
    wait_w(s, 1'b0);
    wait_w(s, 1'b1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_off();
    @(posedge ref_clk);
    en <= 1'b1;
    tick(30);
    chk({7'h00, run}, 8'h00);
    chk({7'h00, flt_oe}, 8'h00);
    @(posedge ref_clk);
    vcc_ok <= 1'b0;
    in_ok  <= 1'b1;
    tick(30);
    chk({7'h00, run}, 8'h00);
    chk(dac, 8'h00);
    @(posedge ref_clk);
    en <= 1'b0;
    $display("test off done");
  endtask
  task automatic t_start();
    @(posedge ref_clk);
    vcc_ok <= 1'b1;
    en     <= 1'b1;
    tick(10);
    chk({7'h00, run}, 8'h00);
    wait_w(7, 1'b1);
    chk({2'b00, unused}, 8'h30);
    chk({2'b00, gshort}, 8'h00);
    d0 = dac;
    tick(1);
    chk(dac, d0 + 8'h01);
    @(posedge ref_clk);
    half <= 1'b1;
    tick(3);
    d0 = dac;
    tick(5);
    chk(dac, d0);
    $display("test start done");
  endtask
  task automatic t_phase();
    @(posedge ref_clk);
    pss <= 1'b0; // late change of the select must be ignored
    tick(2000);
    rise(0);
    t0 = cyc;
    for (int i = 1; i < 4; i++) begin
      rise(i);
      chk_near(cyc - t0, i * PER / 4);
    end
    chk({2'b00, str_en & 6'h30}, 8'h00);
    $display("test phase done");
  endtask
  task automatic t_dac();
    @(posedge ref_clk);
    mlow <= 1'b1;
    rise(6);
    tick(4);
    d0 = dac;
    rise(6);
    tick(4);
    chk(dac, d0 + 8'h01);
    @(posedge ref_clk);
    mlow  <= 1'b0;
    mhigh <= 1'b1;
    rise(6);
    tick(4);
    d0 = dac;
    rise(6);
    tick(4);
    chk(dac, d0 - 8'h01);
    @(posedge ref_clk);
    mhigh <= 1'b0;
    $display("test dac done");
  endtask
  task automatic t_fault();
    @(posedge ref_clk);
    copen <= 6'h30; // opens on strings found unused
    tick(4);
    chk({7'h00, flt_oe}, 8'h00);
    @(posedge ref_clk);
    copen  <= 6'h00;
    cshort <= 6'h08;
    tick(3);
    chk({7'h00, flt_oe}, 8'h01);
    chk({7'h00, flt_o}, 8'h00);
    @(posedge ref_clk);
    cshort <= 6'h00;
    tick(3);
    chk({7'h00, flt_oe}, 8'h00);
    @(posedge ref_clk);
    copen <= 6'h02;
    tick(3);
    chk({7'h00, flt_oe}, 8'h01);
    rise(0);
    t0 = cyc;
    rise(2);
    chk_near(cyc - t0, PER / 2);
    @(posedge ref_clk);
    copen <= 6'h00;
    tick(10);
    chk({7'h00, flt_oe}, 8'h01);
    @(posedge ref_clk);
    therm <= 1'b1;
    tick(3);
    chk({7'h00, flt_oe}, 8'h01);
    @(posedge ref_clk);
    en    <= 1'b0;
    therm <= 1'b0;
    tick(3);
    chk(dac, 8'h00);
    chk({7'h00, run}, 8'h00);
    @(posedge ref_clk);
    en <= 1'b1;
    tick(3);
    chk({7'h00, flt_oe}, 8'h00);
    $display("test fault done");
  endtask
  task automatic t_dither();
    int nz;
    int ups;
    nz  = 0;
    ups = 0;
    @(posedge ref_clk);
    spread_spectrum_mode <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      tick(1);
      chk({7'h00, dith > 8'h3c}, 8'h00);
      if (dith != 8'h00) nz++;
      if (dup === 1'b1) ups++;
    end
    chk({7'h00, nz > 0}, 8'h01);
    chk({7'h00, ups > 0 && ups < 64}, 8'h01);
    @(posedge ref_clk);
    spread_spectrum_mode <= 1'b0;
    tick(3);
    chk(dith, 8'h00);
    $display("test dither done");
  endtask
  task automatic t_flat();
    @(posedge ref_clk);
    rst     <= 1'b1;
    en      <= 1'b0;
    pss     <= 1'b0; // paralleled sinks need simultaneous dimming
    bshort  <= 6'h01;
    bunused <= 6'h01;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    en  <= 1'b1;
    wait_w(7, 1'b1);
    chk({2'b00, gshort}, 8'h01);
    chk({2'b00, unused}, 8'h00);
    tick(2500);
    rise(6);
    t0 = cyc;
    rise(1);
    chk_near(cyc - t0, 2);
    tick(4);
    chk({3'b000, str_en[5:1]}, 8'h1f);
    wait_w(6, 1'b0);
    tick(6);
    chk({3'b000, str_en[5:1]}, 8'h00);
    $display("test flat done");
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    tick(1);
    chk(dac, 8'h00);
    chk({2'b00, str_en}, 8'h00);
    chk({7'h00, flt_oe}, 8'h00);
    t_off();
    t_start();
    t_phase();
    t_dac();
    t_fault();
    t_dither();
    t_flat();
    tally_and_finish();
  end
endmodule
